// *** include/mst_params.svh ***
`ifndef MST_PARAMS_SVH
`define MST_PARAMS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define MST_ADDR_W 8
`define MST_OFS_STATUS 8'h00
`define MST_OFS_IRQ_STAT 8'h04
`define MST_OFS_IRQ_MASK 8'h08
`define MST_OFS_CTRL 8'h0c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MST_IDLE_BIT 31
`define MST_CODE_LSB 20
`define MST_CHAN_LSB 16
`define MST_IRQ_FAULT_BIT 0
`define MST_IRQ_IDLE_BIT 1
`define MST_CTRL_ENABLE_BIT 0

// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define MST_MASK_RST 2'h0
`define MST_CTRL_RST 1'h1
`define MST_CODE_NONE 4'h0
`define MST_CODE_NO_FIRST 4'h1
`define MST_CODE_NOT_OWNED 4'h2
`define MST_CODE_NULL_NEXT 4'h3
`define MST_CODE_NULL_PTR 4'h4
`define MST_CODE_NULL_LEN 4'h5
`define MST_CODE_SHORT 4'h6

`endif

// *** include/mst_pkg.sv ***
package mst_pkg;

    // descriptor fields examined by the transmit checker
    typedef struct packed {
        logic first_buffer_flag;
        logic last_buffer_flag;
        logic owned;
        logic [31:0] next_ptr;
        logic [31:0] buf_ptr;
        logic [15:0] buf_len;
        logic [15:0] pkt_len;
    } mst_desc_s;

    typedef struct packed {
        logic valid;
        logic [2:0] channel;
        mst_desc_s desc;
    } mst_desc_req_s;

    typedef struct packed {
        logic fault;
        logic [3:0] code;
    } mst_check_s;

    typedef enum logic [2:0] {
        MST_ST_RESET = 3'b001,
        MST_ST_RUN = 3'b010,
        MST_ST_FAULT = 3'b100
    } mst_state_e;

endpackage : mst_pkg

// *** verilog/mst_desc_check.sv ***
`timescale 1ns/1ps
`include "mst_params.svh"

module mst_desc_check
    import mst_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input mst_desc_req_s req,
    output mst_check_s result
);

    logic in_packet_q;
    logic [16:0] sum_q;
    logic [16:0] sum_now;
    mst_check_s res;

    assign sum_now = sum_q + {1'b0, req.desc.buf_len};

    // ----------------------------------------------------------------
    // priority: first listed check wins
    // ----------------------------------------------------------------
    always_comb begin
        res = '0;
        if (req.valid) begin
            if (!in_packet_q && !req.desc.first_buffer_flag) begin
                res = '{fault: 1'b1, code: `MST_CODE_NO_FIRST}; // [RULE_04]
            end else if (!in_packet_q && !req.desc.owned) begin
                res = '{fault: 1'b1, code: `MST_CODE_NOT_OWNED}; // [RULE_04]
            end else if (req.desc.next_ptr == 32'h0000_0000 && !req.desc.last_buffer_flag) begin
                res = '{fault: 1'b1, code: `MST_CODE_NULL_NEXT}; // [RULE_05]
            end else if (req.desc.buf_ptr == 32'h0000_0000) begin
                res = '{fault: 1'b1, code: `MST_CODE_NULL_PTR}; // [RULE_05]
            end else if (req.desc.buf_len == 16'h0000) begin
                res = '{fault: 1'b1, code: `MST_CODE_NULL_LEN}; // [RULE_05]
            end else if (req.desc.last_buffer_flag && (sum_now < {1'b0, req.desc.pkt_len})) begin
                // zero packet length never trips this compare
                res = '{fault: 1'b1, code: `MST_CODE_SHORT}; // [RULE_06] [RULE_09]
            end
        end
    end

    assign result = res;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            in_packet_q <= 1'b0;
        end else if (req.valid) begin
            in_packet_q <= !req.desc.last_buffer_flag;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sum_q <= 17'h0_0000;
        end else if (req.valid) begin
            sum_q <= req.desc.last_buffer_flag ? 17'h0_0000 : sum_now;
        end
    end

endmodule : mst_desc_check

// *** verilog/mst_status_regs.sv ***
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "mst_params.svh"

// Operation
// [RULE_01] The idle bit 31 reads 0 during reset and becomes 1 one clock after release.
// [RULE_02] The idle bit reads 1 in the idle state and 0 while the MAC is active.
// [RULE_03] Bits 23..20 hold the transmit host fault code, 0 meaning no fault.
// [RULE_04] Code 1 means first buffer lacks its first flag, code 2 means it is not owned.
// [RULE_05] Code 3 is null next pointer without last flag, 4 null buffer pointer, 5 zero length.
// [RULE_06] Code 6 means summed buffer lengths fall short of packet length; 7..F unused.
// [RULE_07] Software reads the fault code after the host fault interrupt.
// [RULE_08] After a fault the block stays faulted until a hardware reset.
// [RULE_09] A zero packet length is not detected and gives no fault code.
// [RULE_10] Bits 18..16 hold the transmit channel 0..7 of the fault.
// [RULE_11] The channel field clears to zero on a host read of the status word.
// [RULE_12] Reserved bits read zero and code and channel are captured together.
module mst_status_regs
    import mst_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [`MST_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input mst_desc_req_s desc_req,
    input wire logic mac_busy,
    output logic tx_halt,
    output logic irq
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    mst_state_e state_q;
    logic [3:0] code_q;
    logic [2:0] chan_q;
    logic [1:0] irq_stat_q;
    logic [1:0] irq_mask_q;
    logic ctrl_en_q;
    logic idle_q;
    logic idle_prev_q;
    logic [31:0] rdata_q;
    logic tx_halt_q;
    logic irq_q;
    mst_check_s chk;
    mst_desc_req_s req_gated;
    logic fault_now;
    logic rd_status;
    logic rd_irq;
    logic [31:0] status_word;
    logic [1:0] irq_events;

    // ----------------------------------------------------------------
    // descriptor checker
    // ----------------------------------------------------------------
    always_comb begin
        req_gated = desc_req;
        req_gated.valid = desc_req.valid && (state_q == MST_ST_RUN) && ctrl_en_q;
    end

    mst_desc_check u_check (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .req(req_gated),
        .result(chk)
    );

    assign fault_now = chk.fault;
    assign rd_status = reg_rd && (reg_addr == `MST_OFS_STATUS);
    assign rd_irq = reg_rd && (reg_addr == `MST_OFS_IRQ_STAT);

    // ----------------------------------------------------------------
    // main state
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q <= MST_ST_RESET;
        end else begin
            case (state_q)
                MST_ST_RESET: state_q <= MST_ST_RUN;
                MST_ST_RUN: begin
                    if (fault_now) begin
                        state_q <= MST_ST_FAULT;
                    end
                end
                MST_ST_FAULT: state_q <= MST_ST_FAULT; // [RULE_08]
                default: state_q <= MST_ST_RESET;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // idle bit
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            idle_q <= 1'b0; // [RULE_01]
        end else begin
            idle_q <= !mac_busy && !req_gated.valid; // [RULE_01] [RULE_02]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            idle_prev_q <= 1'b0;
        end else begin
            idle_prev_q <= idle_q;
        end
    end

    // ----------------------------------------------------------------
    // fault code and channel
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            code_q <= `MST_CODE_NONE;
        end else if (fault_now) begin
            code_q <= chk.code; // [RULE_03] [RULE_12]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            chan_q <= 3'h0;
        end else if (fault_now) begin
            chan_q <= desc_req.channel; // [RULE_10] [RULE_12]
        end else if (rd_status) begin
            chan_q <= 3'h0; // [RULE_11]
        end
    end

    // ----------------------------------------------------------------
    // interrupt status, mask, control
    // ----------------------------------------------------------------
    assign irq_events[`MST_IRQ_FAULT_BIT] = fault_now;
    assign irq_events[`MST_IRQ_IDLE_BIT] = idle_q && !idle_prev_q;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_irq
            always_ff @(posedge clk_sys) begin
                if (!rst_n) begin
                    irq_stat_q[gi] <= 1'b0;
                end else if (irq_events[gi]) begin
                    irq_stat_q[gi] <= 1'b1;
                end else if (rd_irq) begin
                    irq_stat_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            irq_mask_q <= `MST_MASK_RST;
        end else if (reg_wr && reg_addr == `MST_OFS_IRQ_MASK) begin
            irq_mask_q <= reg_wdata[1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_en_q <= `MST_CTRL_RST;
        end else if (reg_wr && reg_addr == `MST_OFS_CTRL) begin
            ctrl_en_q <= reg_wdata[`MST_CTRL_ENABLE_BIT];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |((irq_stat_q | irq_events) & irq_mask_q);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tx_halt_q <= 1'b0;
        end else begin
            tx_halt_q <= (state_q == MST_ST_FAULT) || fault_now; // [RULE_08]
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    always_comb begin
        status_word = 32'h0000_0000; // [RULE_12]
        status_word[`MST_IDLE_BIT] = idle_q;
        status_word[`MST_CODE_LSB +: 4] = code_q;
        status_word[`MST_CHAN_LSB +: 3] = chan_q;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `MST_OFS_STATUS: rdata_q <= status_word;
                `MST_OFS_IRQ_STAT: rdata_q <= {30'h0000_0000, irq_stat_q};
                `MST_OFS_IRQ_MASK: rdata_q <= {30'h0000_0000, irq_mask_q};
                `MST_OFS_CTRL: rdata_q <= {31'h0000_0000, ctrl_en_q};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_q;
    assign tx_halt = tx_halt_q;
    assign irq = irq_q;

endmodule : mst_status_regs

// *** verification/mst_status_sva.sv ***
`timescale 1ns/1ps
`include "mst_params.svh"

module mst_status_sva
    import mst_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [`MST_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input mst_desc_req_s desc_req,
    input wire logic mac_busy,
    input wire logic tx_halt,
    input wire logic irq
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    logic rd_st;
    logic quiet;
    assign rd_st = reg_rd && reg_addr == `MST_OFS_STATUS;
    assign quiet = !mac_busy && !desc_req.valid;

    reset_quiet_a: assert property (disable iff (1'b0) !rst_n |=> reg_rdata == 32'h0000_0000 && !irq && !tx_halt)
        else $error("outputs not quiet in reset");
    idle_free_a: assert property (rd_st && quiet && $past(quiet) && $past(rst_n) |=> reg_rdata[31])
        else $error("idle bit low while idle");
    idle_busy_a: assert property (rd_st && mac_busy && $past(mac_busy) |=> !reg_rdata[31])
        else $error("idle bit high while busy");
    reserved_zero_a: assert property ($past(rd_st) |-> reg_rdata[30:24] == 7'h00 && !reg_rdata[19])
        else $error("reserved bits set");
    halt_sticky_a: assert property (tx_halt |=> tx_halt)
        else $error("fault left without reset");
    code_halt_a: assert property ($past(rd_st) && $past(tx_halt) |-> reg_rdata[23:20] inside {[4'h1:4'h6]})
        else $error("fault code missing or unused value");
    code_none_a: assert property ($past(rd_st) && !tx_halt |-> reg_rdata[23:20] == 4'h0)
        else $error("fault code without fault");
    chan_clear_a: assert property (rd_st && tx_halt ##1 rd_st |=> reg_rdata[18:16] == 3'h0)
        else $error("channel not cleared by read");
    mask_off_a: assert property (reg_wr && reg_addr == `MST_OFS_IRQ_MASK && reg_wdata[1:0] == 2'h0 ##1 !reg_wr |=> !irq)
        else $error("irq high with mask clear");
endmodule : mst_status_sva

bind mst_status_regs mst_status_sva chk_u (.*);

// *** verification/mac_status_tx_error_report_test.sv ***
`timescale 1ns/1ps
`include "mst_params.svh"

module mac_status_tx_error_report_test
    import mst_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst_n, reg_wr, reg_rd, mac_busy, tx_halt, irq;
    logic [`MST_ADDR_W-1:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, exp;
    mst_desc_req_s desc_req;
    int fail_count = 0;
    int samples_checked = 0;

    always #2.5 clk_sys = ~clk_sys;

    mst_status_regs dut_u (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .desc_req, .mac_busy, .tx_halt, .irq);

    // ------------------------------------------------------------
    // bus and descriptor tasks
    // ------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] want);
        samples_checked++;
        if (got !== want) begin
            fail_count++;
            $display("Error %0t: got %h expected %h", $time, got, want);
        end
    endtask : chk

    task rd(input logic [7:0] a, input logic [31:0] want);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, want);
    endtask : rd

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    task send(input logic [2:0] ch, input logic f, l, o, input logic [31:0] n, p, input logic [15:0] len, pk);
        @(posedge clk_sys);
        desc_req <= '{1'b1, ch, '{f, l, o, n, p, len, pk}};
        @(posedge clk_sys);
        desc_req.valid <= 1'b0;
    endtask : send

    task do_reset();
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        // strobe sampled on the second edge after release
        rd(`MST_OFS_STATUS, 32'h8000_0000);
    endtask : do_reset

    task conclude();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        {rst_n, reg_wr, reg_rd, mac_busy} = 4'h0;
        reg_addr = '0;
        reg_wdata = '0;
        desc_req = '0;
        do_reset();
        rd(`MST_OFS_STATUS, 32'h8000_0000);
        @(posedge clk_sys);
        mac_busy <= 1'b1;
        @(posedge clk_sys);
        rd(`MST_OFS_STATUS, 32'h0000_0000);
        @(posedge clk_sys);
        mac_busy <= 1'b0;
        rd(8'h40, 32'h0000_0000);
        wr(`MST_OFS_CTRL, 32'h0000_0000);
        send(3'h1, 1'b0, 1'b1, 1'b1, 32'h0000_0000, 32'h0000_0100, 16'h0004, 16'h0004);
        rd(`MST_OFS_STATUS, 32'h8000_0000);
        wr(`MST_OFS_CTRL, 32'h0000_0001);
        rd(`MST_OFS_CTRL, 32'h0000_0001);
        send(3'h2, 1'b1, 1'b1, 1'b1, 32'h0000_0000, 32'h0000_0100, 16'h0004, 16'h0000);
        rd(`MST_OFS_STATUS, 32'h8000_0000);
        chk(32'(tx_halt), 32'h0000_0000);
        // two-buffer packet whose lengths add up exactly
        send(3'h3, 1'b1, 1'b0, 1'b1, 32'h0000_0200, 32'h0000_0100, 16'h0004, 16'h0000);
        send(3'h3, 1'b0, 1'b1, 1'b0, 32'h0000_0000, 32'h0000_0100, 16'h0004, 16'h0008);
        rd(`MST_OFS_STATUS, 32'h8000_0000);
        chk(32'(tx_halt), 32'h0000_0000);
        // fault with mask clear, then unmask and mask again
        send(3'h5, 1'b1, 1'b1, 1'b1, 32'h0000_0000, 32'h0000_0100, 16'h0004, 16'h0008);
        #1 chk(32'(irq), 32'h0000_0000);
        wr(`MST_OFS_IRQ_MASK, 32'h0000_0001);
        @(posedge clk_sys);
        #1 chk(32'(irq), 32'h0000_0001);
        wr(`MST_OFS_IRQ_MASK, 32'h0000_0000);
        @(posedge clk_sys);
        #1 chk(32'(irq), 32'h0000_0000);
        for (int k = 1; k <= 6; k++) begin
            do_reset();
            wr(`MST_OFS_IRQ_MASK, 32'h0000_0001);
            send(3'(k + 1), k != 1, k != 3, k != 2, 32'h0000_0000, (k == 4) ? 32'h0000_0000 : 32'h0000_0100,
                (k == 5) ? 16'h0000 : 16'h0004, (k == 6) ? 16'h0008 : 16'h0004);
            #1 chk(32'(irq), 32'h0000_0001);
            exp = 32'h8000_0000 | 32'(k << 20) | 32'((k + 1) << 16);
            @(posedge clk_sys);
            reg_rd <= 1'b1;
            reg_addr <= `MST_OFS_STATUS;
            @(posedge clk_sys);
            #1 chk(reg_rdata, exp);
            @(posedge clk_sys);
            reg_rd <= 1'b0;
            #1 chk(reg_rdata, exp & 32'hfff8_ffff);
            send(3'h0, 1'b0, 1'b1, 1'b1, 32'h0000_0000, 32'h0000_0100, 16'h0004, 16'h0004);
            wr(`MST_OFS_STATUS, 32'hffff_ffff);
            rd(`MST_OFS_STATUS, exp & 32'hfff8_ffff);
            chk(32'(tx_halt), 32'h0000_0001);
            rd(`MST_OFS_IRQ_STAT, 32'h0000_0003);
            rd(`MST_OFS_IRQ_STAT, 32'h0000_0000);
            chk(32'(irq), 32'h0000_0000);
            rd(`MST_OFS_IRQ_MASK, 32'h0000_0001);
        end
        conclude();
    end

    initial begin
        #100000;
        fail_count++;
        conclude();
    end
endmodule : mac_status_tx_error_report_test
